// >>> hdl/acrf_pkg.sv
// constants and carrier types of the converter range-flag output block
// assumes one 100 MHz system clock; converter clock arrives as a synchronous level
package acrf_pkg;

  // ==========================================================
  // widths and pipeline latency
  localparam int ACRF_DATA_W  = 12;
  localparam int ACRF_IN_W    = 14;
  localparam int ACRF_LATENCY = 3;

  // ==========================================================
  // codes and limits
  localparam logic [ACRF_DATA_W-1:0] ACRF_CODE_MIN = 12'h000;
  localparam logic [ACRF_DATA_W-1:0] ACRF_CODE_MID = 12'h800;
  localparam logic [ACRF_DATA_W-1:0] ACRF_CODE_MAX = 12'hFFF;
  localparam logic signed [ACRF_IN_W-1:0] ACRF_IN_MAX = 14'sh07FF;
  localparam logic signed [ACRF_IN_W-1:0] ACRF_IN_MIN = 14'sh3800;

  // ==========================================================
  // reset values
  localparam logic [ACRF_DATA_W-1:0] ACRF_WORD_RST = 12'h000;
  localparam logic                   ACRF_FLAG_RST = 1'b0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ACRF_DATA_W-1:0] word;
    logic                   range_exceeded_flag;
  } acrf_sample_type;

  typedef struct packed {
    logic            conv_prev;
    acrf_sample_type held;
    acrf_sample_type out;
    logic            out_stb;
  } acrf_main_type;

  localparam acrf_sample_type ACRF_SAMPLE_RST = '{word: ACRF_WORD_RST, range_exceeded_flag: ACRF_FLAG_RST};

endpackage // acrf_pkg

// >>> hdl/acrf_stage.sv
// one pipeline stage carrying a sample word with its range flag
// assumes advance pulses come from the converter clock falling edge
module acrf_stage (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // data path
  input  wire logic                      adv,
  input  wire acrf_pkg::acrf_sample_type d,
  output acrf_pkg::acrf_sample_type      q
);
  import acrf_pkg::*;

  acrf_sample_type state_q;
  acrf_sample_type state_d;

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    if (adv) begin
      state_d = d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ACRF_SAMPLE_RST;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign q = state_q;

endmodule // acrf_stage

// >>> hdl/acrf_top.sv
// output side of a pipelined converter: straight-binary word plus range flag
// assumes conv_clk and diff_in are synchronous to clock
module acrf_top #(
  parameter int LATENCY = acrf_pkg::ACRF_LATENCY
) (
  // clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  input  wire logic                                     ce,
  // converter core
  input  wire logic                                     conv_clk,
  input  wire logic signed [acrf_pkg::ACRF_IN_W-1:0]    diff_in,
  // sample output
  output logic             [acrf_pkg::ACRF_DATA_W-1:0]  sample_word,
  output logic                                          range_exceeded_flag,
  output logic                                          sample_stb
);
  import acrf_pkg::*;

  acrf_main_type   st_q;
  acrf_main_type   st_d;
  acrf_sample_type conv;
  acrf_sample_type pipe [LATENCY+1];
  logic            rise;
  logic            fall;
  logic            in_range;

  // ==========================================================
  // converter clock phases
  assign rise = conv_clk & ~st_q.conv_prev;
  assign fall = ~conv_clk & st_q.conv_prev;

  // ==========================================================
  // quantiser: clamp and offset to straight binary
  always_comb begin
    conv.word                = diff_in[ACRF_DATA_W-1:0] ^ ACRF_CODE_MID;
    conv.range_exceeded_flag = 1'b0;
    if (diff_in > ACRF_IN_MAX) begin
      conv.word                = ACRF_CODE_MAX;
      conv.range_exceeded_flag = 1'b1;
    end else if (diff_in < ACRF_IN_MIN) begin
      conv.word                = ACRF_CODE_MIN;
      conv.range_exceeded_flag = 1'b1;
    end
  end

  // ==========================================================
  // pipeline, word and flag travel as one struct
  assign pipe[0] = st_q.held;

  for (genvar i = 0; i < LATENCY; i++) begin : g_stage
    acrf_stage u_stage (
      .clock (clock),
      .rst_n (rst_n),
      .ce    (ce),
      .adv   (fall),
      .d     (pipe[i]),
      .q     (pipe[i+1])
    );
  end

  // ==========================================================
  // sample on rising edge, advance and present on falling edge
  always_comb begin
    st_d           = st_q;
    st_d.conv_prev = conv_clk;
    st_d.out_stb   = 1'b0;
    if (rise) begin
      st_d.held = conv;
    end
    if (fall) begin
      st_d.out     = pipe[LATENCY];
      st_d.out_stb = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{conv_prev: 1'b0, held: ACRF_SAMPLE_RST, out: ACRF_SAMPLE_RST, out_stb: 1'b0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign sample_word         = st_q.out.word;
  assign range_exceeded_flag = st_q.out.range_exceeded_flag;
  assign sample_stb          = st_q.out_stb;

  // ==========================================================
  // checks
  assign in_range = (diff_in <= ACRF_IN_MAX) && (diff_in >= ACRF_IN_MIN);

  a_flag_with_word: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(range_exceeded_flag) |-> $changed(sample_stb) && sample_stb)
    else $error("range flag moved without a sample update");

  a_flag_in_range: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && diff_in <= ACRF_IN_MAX && diff_in >= ACRF_IN_MIN) |=> !st_q.held.range_exceeded_flag)
    else $error("in-range sample flagged");

  a_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (range_exceeded_flag && !(ce && fall)) |=> range_exceeded_flag)
    else $error("range flag dropped between samples");

  a_sample_on_rise: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && !rise) |=> $stable(st_q.held))
    else $error("sample taken outside rising phase");

  a_over_code: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && diff_in > ACRF_IN_MAX) |=> st_q.held.word == ACRF_CODE_MAX && st_q.held.range_exceeded_flag)
    else $error("overrange code wrong");

  a_mid_code: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && diff_in == '0) |=> st_q.held.word == ACRF_CODE_MID && !st_q.held.range_exceeded_flag)
    else $error("midscale code wrong");

  a_under_code: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && diff_in < ACRF_IN_MIN)
    |=> st_q.held.word == ACRF_CODE_MIN && st_q.held.range_exceeded_flag)
    else $error("underrange code wrong");

  a_in_code: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && in_range)
    |=> st_q.held.word == {~$past(diff_in[ACRF_DATA_W-1]), $past(diff_in[ACRF_DATA_W-2:0])})
    else $error("in-range code wrong");

  a_top_code: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && diff_in == ACRF_IN_MAX)
    |=> st_q.held.word == ACRF_CODE_MAX && !st_q.held.range_exceeded_flag)
    else $error("top in-range code wrong");

  a_bottom_code: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && diff_in == ACRF_IN_MIN)
    |=> st_q.held.word == ACRF_CODE_MIN && !st_q.held.range_exceeded_flag)
    else $error("bottom in-range code wrong");

  a_flag_out_range: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise && !in_range)
    |=> st_q.held.range_exceeded_flag)
    else $error("out-of-range sample not flagged");

  // ==========================================================
  // pipeline checks
  a_stage_entry: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall)
    |=> pipe[1] == $past(st_q.held))
    else $error("held sample not moved into first stage");

  a_out_from_last: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall)
    |=> st_q.out == $past(pipe[LATENCY]))
    else $error("output not taken from last stage");

  a_stage_still: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && !fall)
    |=> $stable(pipe[LATENCY]))
    else $error("last stage moved outside falling phase");

  a_word_still: assert property (@(posedge clock) disable iff (!rst_n)
    !(ce && fall)
    |=> $stable(sample_word) && $stable(range_exceeded_flag))
    else $error("sample output moved outside falling phase");

  a_stb_after_fall: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall)
    |=> sample_stb)
    else $error("no strobe after sample update");

  a_stb_only_fall: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && !fall)
    |=> !sample_stb)
    else $error("strobe without sample update");

  a_stb_single: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && sample_stb)
    |=> !sample_stb)
    else $error("strobe longer than one cycle");

  a_freeze_all: assert property (@(posedge clock) disable iff (!rst_n)
    !ce
    |=> $stable(st_q) && $stable(pipe[LATENCY]))
    else $error("state moved while clock enable low");

  // ==========================================================
  // range flag checks
  a_flag_codes: assert property (@(posedge clock) disable iff (!rst_n)
    range_exceeded_flag
    |-> (sample_word == ACRF_CODE_MAX) || (sample_word == ACRF_CODE_MIN))
    else $error("range flag with a code inside the span");

  a_flag_sets: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall && pipe[LATENCY].range_exceeded_flag)
    |=> range_exceeded_flag)
    else $error("flagged sample output without flag");

  a_flag_clears: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall && !pipe[LATENCY].range_exceeded_flag)
    |=> !range_exceeded_flag)
    else $error("range flag stuck after in-range sample");

  // ==========================================================
  // converter clock checks
  a_prev_follows: assert property (@(posedge clock) disable iff (!rst_n)
    ce
    |=> st_q.conv_prev == $past(conv_clk))
    else $error("converter clock phase tracking lost");

  // ==========================================================
  // scenario covers
  c_over: cover property (@(posedge clock) disable iff (!rst_n)
    sample_stb && range_exceeded_flag && sample_word[ACRF_DATA_W-1]);
  c_under: cover property (@(posedge clock) disable iff (!rst_n)
    sample_stb && range_exceeded_flag && !sample_word[ACRF_DATA_W-1]);
  c_recover: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(range_exceeded_flag));
  c_freeze: cover property (@(posedge clock) disable iff (!rst_n)
    !ce ##1 ce);
  c_midscale: cover property (@(posedge clock) disable iff (!rst_n)
    sample_stb && !range_exceeded_flag && sample_word == ACRF_CODE_MID);

endmodule // acrf_top

// >>> verif/acrf_rx_model.sv
// receiver model: makes the converter clock, captures and decodes samples
// assumes clock is the system clock of acrf_top
module acrf_rx_model (
  // clock and reset
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  // sample input
  input  wire logic [acrf_pkg::ACRF_DATA_W-1:0] sample_word,
  input  wire logic                             range_exceeded_flag,
  input  wire logic                             sample_stb,
  // converter clock and results
  output logic                                  conv_clk,
  output logic      [1:0]                       cls,
  output logic      [acrf_pkg::ACRF_DATA_W-1:0] twos
);
  import acrf_pkg::*;
  logic [1:0] div_q;
  // ==========================================
  // clock divider and capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q    <= 2'h0;
      conv_clk <= 1'b0;
      cls      <= 2'h0;
      twos     <= 12'h000;
    end else begin
      div_q    <= div_q + 2'h1;
      conv_clk <= div_q[1];
      if (sample_stb) begin
        cls  <= range_exceeded_flag ? (sample_word[11] ? 2'h2 : 2'h1) : 2'h0;
        twos <= sample_word ^ 12'h800;
      end
    end
  end
endmodule // acrf_rx_model

// >>> verif/testbench.sv
// self-checking bench of the converter range-flag output
// assumes acrf_top and acrf_rx_model are compiled before it
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acrf_pkg::*;
  logic                          clock = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          ce = 1'b1;
  logic                          conv_clk;
  logic signed [ACRF_IN_W-1:0]   diff_in = '0;
  logic        [ACRF_DATA_W-1:0] sample_word, twos, pw;
  logic                          range_exceeded_flag, sample_stb, pf;
  logic        [1:0]             cls;
  int                            fails = 0;
  int                            samples_checked = 0;
  int                            cycles = 0;
  logic signed [ACRF_IN_W-1:0] tbl [8] = '{14'sh0, 14'sh07FF, 14'sh3800, 14'sh0800, 14'sh07FF, 14'sh37FF,
    14'sh0005, 14'sh3FFF};
  acrf_top #(.LATENCY(1)) dut (.clock(clock), .rst_n(rst_n), .ce(ce), .conv_clk(conv_clk), .diff_in(diff_in),
    .sample_word(sample_word), .range_exceeded_flag(range_exceeded_flag), .sample_stb(sample_stb));
  acrf_rx_model rx (.clock(clock), .rst_n(rst_n), .sample_word(sample_word),
    .range_exceeded_flag(range_exceeded_flag), .sample_stb(sample_stb), .conv_clk(conv_clk), .cls(cls), .twos(twos));
  // ==========================================
  // clock and timeout
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      close_out();
    end
  end
  // ==========================================
  // checks and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_code(input logic signed [ACRF_IN_W-1:0] v);
    logic [ACRF_DATA_W-1:0] w;
    logic                   f;
    int                     n;
    f = (v > ACRF_IN_MAX) || (v < ACRF_IN_MIN);
    w = (v > ACRF_IN_MAX) ? ACRF_CODE_MAX : (v < ACRF_IN_MIN) ? ACRF_CODE_MIN : (v[11:0] ^ ACRF_CODE_MID);
    @(negedge clock);
    diff_in = v;
    repeat (2) @(negedge clock);
    chk({3'h0, range_exceeded_flag, sample_word}, {3'h0, pf, pw});
    repeat (24) @(negedge clock);
    chk({3'h0, range_exceeded_flag, sample_word}, {3'h0, f, w});
    chk({14'h0, cls}, {14'h0, f ? (w[11] ? 2'h2 : 2'h1) : 2'h0});
    chk({4'h0, twos}, {4'h0, w ^ 12'h800});
    n = 0;
    repeat (8) begin
      @(negedge clock);
      n = n + int'(sample_stb);
    end
    chk(n[15:0], 16'h0002);
    pw = w;
    pf = f;
  endtask
  task automatic t_freeze();
    @(negedge clock);
    ce = 1'b0;
    diff_in = 14'sh0064;
    repeat (24) @(negedge clock);
    chk({3'h0, range_exceeded_flag, sample_word}, {3'h0, pf, pw});
    ce = 1'b1;
    t_code(14'sh0064);
  endtask
  // ==========================================
  // main sequence
  initial begin
    pw = ACRF_CODE_MID;
    pf = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (24) @(negedge clock);
    foreach (tbl[i]) t_code(tbl[i]);
    t_freeze();
    close_out();
  end
endmodule // testbench
